// ---- rtl/psir_cfg.svh ----
// Constants of the pressure status input register bank.
// Assumes inclusion by bare name from every file that needs an index or limit.
`ifndef PSIR_CFG_SVH
`define PSIR_CFG_SVH

// ---------------------------------------------------------------
// Register indices on the read port
// ---------------------------------------------------------------
`define PSIR_IDX_PRESSURE_LEVEL 8'h01
`define PSIR_IDX_FLOW_RATE_HIGH 8'h02
`define PSIR_IDX_FLOW_RATE_LOW 8'h03
`define PSIR_IDX_AIR_VELOCITY 8'h04
`define PSIR_IDX_OUTPUT_PERCENT 8'h05
`define PSIR_IDX_MAX_FLOW_HIGH 8'h06
`define PSIR_IDX_MAX_FLOW_LOW 8'h07
`define PSIR_IDX_SPAN_FLAG 8'h08
`define PSIR_IDX_ALERT_FLAG 8'h09
`define PSIR_IDX_FEEDBACK_LOST 8'h0a
`define PSIR_IDX_SENSOR_FAULT 8'h0b
`define PSIR_IDX_RSVD_FIRST 8'h0c
`define PSIR_IDX_RSVD_LAST 8'h14

// ---------------------------------------------------------------
// Raw ranges and scaling
// ---------------------------------------------------------------
`define PSIR_OUT_RAW_MAX 16'h03e8
`define PSIR_VEL_RAW_MAX 16'h012c
`define PSIR_AREA_SCALE_MUL 48'h0000_0000_0024
`define PSIR_AREA_SCALE_DIV 48'h0000_0000_03e8
`define PSIR_FLOW_SAT 48'h0000_ffff_ffff

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PSIR_WORD_RST 16'h0000
`define PSIR_FLOW_RST 32'h0000_0000

`endif

// ---- rtl/psir_pkg.sv ----
// Types shared by the pressure status input register bank.
// Assumes the constants header is included where indices are needed.
package psir_pkg;

  // ---------------------------------------------------------------
  // Data types
  // ---------------------------------------------------------------
  typedef logic [15:0] psir_word_t;
  typedef logic [31:0] psir_flow_t;
  typedef logic [7:0] psir_idx_t;

  // Source of the maximum flow figure
  typedef enum logic [1:0] {
    PSIR_SRC_KFACTOR = 2'b01,
    PSIR_SRC_AREA = 2'b10
  } psir_src_e;

endpackage

// ---- rtl/psir_clamp.sv ----
// Saturating clamp of a raw measurement to its documented full scale.
// Assumes value and limit arrive on the same clock as the caller.
`timescale 1ns/10ps

module psir_clamp #(
  parameter int W = 16,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic [W-1:0] i_value,
  output logic [W-1:0] o_value
);

  // ---------------------------------------------------------------
  // Clamp
  // ---------------------------------------------------------------
  // A glitching core value never shows above full scale
  assign o_value = (i_value > MAX) ? MAX : i_value;

endmodule

// ---- rtl/psir_window.sv ----
// Window comparator: flags a value that lies outside a low/high pair.
// Assumes limits come from the writable configuration bank, low <= high.
`timescale 1ns/10ps

module psir_window #(
  parameter int W = 16
) (
  input wire logic i_enable,
  input wire logic [W-1:0] i_value,
  input wire logic [W-1:0] i_low,
  input wire logic [W-1:0] i_high,
  output logic o_outside
);

  // ---------------------------------------------------------------
  // Compare
  // ---------------------------------------------------------------
  // Disabled quantities never raise a flag
  assign o_outside = i_enable && ((i_value < i_low) || (i_value > i_high));

endmodule

// ---- rtl/psir_bank.sv ----
// Read-only measurement and status register bank of the pressure controller.
// Assumes all measurement and configuration inputs come from logic on i_clk.
//
// Behaviour
// RQ1: Output command reported in tenths, max 1000.
// RQ2: Velocity reported only while velocity enable set.
// RQ3: Flow valid only with velocity enable and pitot.
// RQ4: Flow high word only on high-range variants.
// RQ5: Max flow high word only on high-range variants.
// RQ6: Max flow from K factor or duct area.
// RQ7: Span flag set outside span limits.
// RQ8: Alert flag set outside alert limits.
// RQ9: Both flags held off during auto tuning.
// RQ10: Feedback lost flag follows feedback state.
// RQ11: Sensor fault flag follows sensor element state.
// RQ12: All registers 16 bits, read only, writes ignored.
`timescale 1ns/10ps
`include "psir_cfg.svh"

module psir_bank #(
  parameter bit P_HIGH_RANGE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire psir_pkg::psir_word_t i_pressure,
  input wire psir_pkg::psir_flow_t i_flow,
  input wire psir_pkg::psir_word_t i_velocity,
  input wire psir_pkg::psir_word_t i_output_cmd,
  input wire psir_pkg::psir_word_t i_k_factor,
  input wire psir_pkg::psir_word_t i_dp_root,
  input wire psir_pkg::psir_word_t i_duct_area,
  input wire psir_pkg::psir_src_e i_max_src,
  input wire logic i_velocity_en,
  input wire logic i_pitot_present,
  input wire logic i_autotune_busy,
  input wire logic i_feedback_lost,
  input wire logic i_sensor_failed,
  input wire psir_pkg::psir_word_t i_span_p_low,
  input wire psir_pkg::psir_word_t i_span_p_high,
  input wire psir_pkg::psir_flow_t i_span_f_low,
  input wire psir_pkg::psir_flow_t i_span_f_high,
  input wire psir_pkg::psir_word_t i_span_v_low,
  input wire psir_pkg::psir_word_t i_span_v_high,
  input wire psir_pkg::psir_word_t i_alert_p_low,
  input wire psir_pkg::psir_word_t i_alert_p_high,
  input wire psir_pkg::psir_flow_t i_alert_f_low,
  input wire psir_pkg::psir_flow_t i_alert_f_high,
  input wire psir_pkg::psir_word_t i_alert_v_low,
  input wire psir_pkg::psir_word_t i_alert_v_high,
  input wire logic i_rd_en,
  input wire psir_pkg::psir_idx_t i_rd_idx,
  input wire logic i_wr_en,
  input wire psir_pkg::psir_idx_t i_wr_idx,
  input wire psir_pkg::psir_word_t i_wr_data,
  output logic o_rd_valid,
  output logic o_rd_err,
  output psir_pkg::psir_word_t o_rd_data,
  output logic o_wr_refused
);
  import psir_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  psir_word_t pressure_level_reg;
  psir_flow_t flow_rate_reg;
  psir_word_t air_velocity_reg;
  psir_word_t output_percent_reg;
  psir_flow_t max_flow_reg;
  logic span_flag_reg;
  logic alert_flag_reg;
  logic feedback_lost_reg;
  logic sensor_fault_reg;
  logic flow_valid;
  logic [47:0] max_flow_wide;
  psir_flow_t max_flow_next;
  psir_word_t output_clamped;
  psir_word_t velocity_clamped;
  logic span_p, span_f, span_v;
  logic alert_p, alert_f, alert_v;
  psir_word_t rd_word;
  logic rd_mapped;
  psir_word_t wr_data_unused;

  // ---------------------------------------------------------------
  // Measurement conditioning
  // ---------------------------------------------------------------
  // Output command stays within 0..1000 tenths of a percent
  psir_clamp #(
    .W(16),
    .MAX(`PSIR_OUT_RAW_MAX)
  ) u_out_clamp (
    .i_value(i_output_cmd),
    .o_value(output_clamped)
  );

  // Velocity stays within 0..300 tenths of a metre per second
  psir_clamp #(
    .W(16),
    .MAX(`PSIR_VEL_RAW_MAX)
  ) u_vel_clamp (
    .i_value(i_velocity),
    .o_value(velocity_clamped)
  );

  // Flow needs the velocity path and a pitot on the ports
  assign flow_valid = i_velocity_en && i_pitot_present; // RQ3

  // ---------------------------------------------------------------
  // Maximum flow calculation
  // ---------------------------------------------------------------
  // Area in cm2 times full-scale velocity, scaled to m3/h; the
  // divider is wide but the result only moves with configuration
  always_comb begin
    max_flow_wide = 48'h0;
    case (i_max_src)
      PSIR_SRC_KFACTOR: begin
        max_flow_wide = {32'h0, i_k_factor} * {32'h0, i_dp_root}; // RQ6
      end
      PSIR_SRC_AREA: begin
        max_flow_wide = ({32'h0, i_duct_area} * {32'h0, `PSIR_VEL_RAW_MAX}
          * `PSIR_AREA_SCALE_MUL) / `PSIR_AREA_SCALE_DIV; // RQ6
      end
      default: begin
        max_flow_wide = 48'h0;
      end
    endcase
  end

  // Saturate rather than wrap on an absurd configuration
  assign max_flow_next = (max_flow_wide > `PSIR_FLOW_SAT) ? 32'hffff_ffff
    : max_flow_wide[31:0];

  // ---------------------------------------------------------------
  // Limit windows
  // ---------------------------------------------------------------
  psir_window #(.W(16)) u_span_p (
    .i_enable(1'b1),
    .i_value(i_pressure),
    .i_low(i_span_p_low),
    .i_high(i_span_p_high),
    .o_outside(span_p)
  );

  psir_window #(.W(32)) u_span_f (
    .i_enable(flow_valid),
    .i_value(i_flow),
    .i_low(i_span_f_low),
    .i_high(i_span_f_high),
    .o_outside(span_f)
  );

  psir_window #(.W(16)) u_span_v (
    .i_enable(i_velocity_en),
    .i_value(velocity_clamped),
    .i_low(i_span_v_low),
    .i_high(i_span_v_high),
    .o_outside(span_v)
  );

  psir_window #(.W(16)) u_alert_p (
    .i_enable(1'b1),
    .i_value(i_pressure),
    .i_low(i_alert_p_low),
    .i_high(i_alert_p_high),
    .o_outside(alert_p)
  );

  psir_window #(.W(32)) u_alert_f (
    .i_enable(flow_valid),
    .i_value(i_flow),
    .i_low(i_alert_f_low),
    .i_high(i_alert_f_high),
    .o_outside(alert_f)
  );

  psir_window #(.W(16)) u_alert_v (
    .i_enable(i_velocity_en),
    .i_value(velocity_clamped),
    .i_low(i_alert_v_low),
    .i_high(i_alert_v_high),
    .o_outside(alert_v)
  );

  // ---------------------------------------------------------------
  // Measurement snapshot
  // ---------------------------------------------------------------
  // Refreshed every cycle so a read sees one consistent word set
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pressure_level_reg <= `PSIR_WORD_RST;
      flow_rate_reg <= `PSIR_FLOW_RST;
      air_velocity_reg <= `PSIR_WORD_RST;
      output_percent_reg <= `PSIR_WORD_RST;
      max_flow_reg <= `PSIR_FLOW_RST;
    end else begin
      pressure_level_reg <= i_pressure;
      flow_rate_reg <= flow_valid ? i_flow : `PSIR_FLOW_RST; // RQ3
      air_velocity_reg <= i_velocity_en ? velocity_clamped : `PSIR_WORD_RST; // RQ2
      output_percent_reg <= output_clamped; // RQ1
      max_flow_reg <= max_flow_next; // RQ6
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Tuning drives the loop far from setpoint, so flags stay quiet
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      span_flag_reg <= 1'b0;
      alert_flag_reg <= 1'b0;
    end else begin
      span_flag_reg <= !i_autotune_busy && (span_p || span_f || span_v); // RQ7 RQ9
      alert_flag_reg <= !i_autotune_busy && (alert_p || alert_f || alert_v); // RQ8 RQ9
    end
  end

  // Fault levels from the core, followed without latching
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      feedback_lost_reg <= 1'b0;
      sensor_fault_reg <= 1'b0;
    end else begin
      feedback_lost_reg <= i_feedback_lost; // RQ10
      sensor_fault_reg <= i_sensor_failed; // RQ11
    end
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  // High words are absent on low-range parts and answer as unmapped
  always_comb begin
    rd_word = `PSIR_WORD_RST;
    rd_mapped = 1'b1;
    case (i_rd_idx)
      `PSIR_IDX_PRESSURE_LEVEL: rd_word = pressure_level_reg;
      `PSIR_IDX_FLOW_RATE_HIGH: begin
        rd_word = flow_rate_reg[31:16];
        rd_mapped = P_HIGH_RANGE; // RQ4
      end
      `PSIR_IDX_FLOW_RATE_LOW: rd_word = flow_rate_reg[15:0];
      `PSIR_IDX_AIR_VELOCITY: rd_word = air_velocity_reg;
      `PSIR_IDX_OUTPUT_PERCENT: rd_word = output_percent_reg;
      `PSIR_IDX_MAX_FLOW_HIGH: begin
        rd_word = max_flow_reg[31:16];
        rd_mapped = P_HIGH_RANGE; // RQ5
      end
      `PSIR_IDX_MAX_FLOW_LOW: rd_word = max_flow_reg[15:0];
      `PSIR_IDX_SPAN_FLAG: rd_word = {15'h0, span_flag_reg};
      `PSIR_IDX_ALERT_FLAG: rd_word = {15'h0, alert_flag_reg};
      `PSIR_IDX_FEEDBACK_LOST: rd_word = {15'h0, feedback_lost_reg};
      `PSIR_IDX_SENSOR_FAULT: rd_word = {15'h0, sensor_fault_reg};
      default: begin
        rd_word = `PSIR_WORD_RST;
        rd_mapped = (i_rd_idx >= `PSIR_IDX_RSVD_FIRST)
          && (i_rd_idx <= `PSIR_IDX_RSVD_LAST);
      end
    endcase
  end

  // Read answer one cycle after the request, data from flops
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_err <= 1'b0;
      o_rd_data <= `PSIR_WORD_RST;
    end else begin
      o_rd_valid <= i_rd_en;
      o_rd_err <= i_rd_en && !rd_mapped;
      o_rd_data <= (i_rd_en && rd_mapped) ? rd_word : `PSIR_WORD_RST;
    end
  end

  // ---------------------------------------------------------------
  // Write refusal
  // ---------------------------------------------------------------
  // Nothing here is writable; the index and data are only absorbed
  assign wr_data_unused = i_wr_data ^ {8'h0, i_wr_idx};

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_wr_refused <= 1'b0;
    end else begin
      o_wr_refused <= i_wr_en; // RQ12
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_read_of(logic [7:0] idx);
    i_rd_en && (i_rd_idx == idx);
  endsequence

  sequence s_tuning_two;
    i_autotune_busy [*2];
  endsequence

  property p_out_clamp;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_output_cmd > `PSIR_OUT_RAW_MAX) |=> (output_percent_reg == `PSIR_OUT_RAW_MAX);
  endproperty
  a_out_clamp: assert property (p_out_clamp) else $error("output above 1000"); // RQ1

  property p_vel_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_velocity_en ##1 s_read_of(`PSIR_IDX_AIR_VELOCITY) |=> (o_rd_data == 16'h0000);
  endproperty
  a_vel_gate: assert property (p_vel_gate) else $error("velocity read while off"); // RQ2

  property p_flow_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      !(i_velocity_en && i_pitot_present) |-> (!span_f && !alert_f)
        ##1 (flow_rate_reg == 32'h0);
  endproperty
  a_flow_gate: assert property (p_flow_gate) else $error("flow without pitot"); // RQ3

  property p_flow_high_absent;
    @(posedge i_clk) disable iff (!i_resetn)
      s_read_of(`PSIR_IDX_FLOW_RATE_HIGH) |=> (o_rd_err == !P_HIGH_RANGE) && o_rd_valid;
  endproperty
  a_flow_high_absent: assert property (p_flow_high_absent) else $error("flow high map"); // RQ4

  property p_max_high_absent;
    @(posedge i_clk) disable iff (!i_resetn)
      s_read_of(`PSIR_IDX_MAX_FLOW_HIGH) |=> (o_rd_err == !P_HIGH_RANGE) && o_rd_valid;
  endproperty
  a_max_high_absent: assert property (p_max_high_absent) else $error("max high map"); // RQ5

  property p_max_kfactor;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_max_src == PSIR_SRC_KFACTOR) |=>
        (max_flow_reg == $past(i_k_factor) * $past(i_dp_root));
  endproperty
  a_max_kfactor: assert property (p_max_kfactor) else $error("max flow wrong"); // RQ6

  property p_span;
    @(posedge i_clk) disable iff (!i_resetn)
      (!i_autotune_busy && ((i_pressure < i_span_p_low) || (i_pressure > i_span_p_high)))
        |=> span_flag_reg;
  endproperty
  a_span: assert property (p_span) else $error("span flag missed"); // RQ7

  property p_alert;
    @(posedge i_clk) disable iff (!i_resetn)
      (!i_autotune_busy && (i_pressure < i_alert_p_low)) |=> alert_flag_reg;
  endproperty
  a_alert: assert property (p_alert) else $error("alert flag missed"); // RQ8

  property p_tune_quiet;
    @(posedge i_clk) disable iff (!i_resetn)
      s_tuning_two |-> !span_flag_reg && !alert_flag_reg;
  endproperty
  a_tune_quiet: assert property (p_tune_quiet) else $error("flag during tuning"); // RQ9

  property p_feedback;
    @(posedge i_clk) disable iff (!i_resetn)
      i_feedback_lost ##1 s_read_of(`PSIR_IDX_FEEDBACK_LOST) |=> (o_rd_data == 16'h0001);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback flag wrong"); // RQ10

  property p_sensor;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_sensor_failed != $past(i_sensor_failed)) |=> (sensor_fault_reg == $past(i_sensor_failed));
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor flag wrong"); // RQ11

  property p_write_ignored;
    @(posedge i_clk) disable iff (!i_resetn)
      i_wr_en && $stable(i_pressure) |=> o_wr_refused && (pressure_level_reg == $past(i_pressure));
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write not refused"); // RQ12

endmodule

// ---- tb/psir_master_model.sv ----
// Polling master model that issues reads and writes to the register bank.
// Assumes a 10 MHz i_clk and strobes launched on the falling edge.
`timescale 1ns/10ps

module psir_master_model (
  input wire logic i_clk,
  output logic o_rd_en,
  output psir_pkg::psir_idx_t o_rd_idx,
  output logic o_wr_en,
  output psir_pkg::psir_idx_t o_wr_idx,
  output psir_pkg::psir_word_t o_wr_data,
  input wire logic i_rd_valid,
  input wire logic i_rd_err,
  input wire psir_pkg::psir_word_t i_rd_data,
  input wire logic i_wr_refused
);
  import psir_pkg::*;

  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  // Strobes low, qualifiers at a non-zero pattern
  initial begin
    o_rd_en = 1'b0;
    o_rd_idx = 8'h5a;
    o_wr_en = 1'b0;
    o_wr_idx = 8'ha5;
    o_wr_data = 16'h5a5a;
  end

  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // One-cycle strobe; the answer stands in the following cycle
  task automatic read(input psir_idx_t idx, output logic v, output logic e,
                      output psir_word_t d);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_rd_idx = idx;
    @(negedge i_clk);
    v = i_rd_valid;
    e = i_rd_err;
    d = i_rd_data;
    o_rd_en = 1'b0;
    o_rd_idx = ~idx; // Released index shows inverse, not last value
  endtask

  // Writes are refused outside reset; data is still driven in earnest
  task automatic write(input psir_idx_t idx, input psir_word_t data, output logic r);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_wr_idx = idx;
    o_wr_data = data;
    @(negedge i_clk);
    r = i_wr_refused;
    o_wr_en = 1'b0;
    o_wr_idx = ~idx;
    o_wr_data = ~data;
  endtask
endmodule

// ---- tb/psir_bank_tb.sv ----
// Self-checking bench of the pressure status register bank, both variants.
// Assumes the master model drives the strobe ports of both instances.
`timescale 1ns/10ps
`include "psir_cfg.svh"

module psir_bank_tb;
  import psir_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic i_clk, i_resetn, i_velocity_en, i_pitot_present, i_autotune_busy;
  logic i_feedback_lost, i_sensor_failed, i_rd_en, i_wr_en;
  psir_word_t i_pressure, i_velocity, i_output_cmd, i_k_factor, i_dp_root, i_duct_area;
  psir_word_t i_span_p_low, i_span_p_high, i_span_v_low, i_span_v_high;
  psir_word_t i_alert_p_low, i_alert_p_high, i_alert_v_low, i_alert_v_high;
  psir_flow_t i_flow, i_span_f_low, i_span_f_high, i_alert_f_low, i_alert_f_high;
  psir_src_e i_max_src;
  psir_idx_t i_rd_idx, i_wr_idx;
  psir_word_t i_wr_data, o_rd_data, lo_data, exp_w;
  logic o_rd_valid, o_rd_err, o_wr_refused, lo_valid, lo_err, lo_refused, ref_bit;
  int fails, compares;
  psir_word_t tab_p [5] = '{16'h0096, 16'h00b4, 16'h00b5, 16'h00c9, 16'h0063};
  logic tab_s [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic tab_a [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  psir_bank #(.P_HIGH_RANGE(1'b1)) psir_bank_i (.*);
  // Low-range variant shares every input; its answers are watched apart
  psir_bank #(.P_HIGH_RANGE(1'b0)) psir_bank_lo_i (.*, .o_rd_valid(lo_valid),
    .o_rd_err(lo_err), .o_rd_data(lo_data), .o_wr_refused(lo_refused));
  psir_master_model psir_master_model_i (.i_clk(i_clk), .o_rd_en(i_rd_en),
    .o_rd_idx(i_rd_idx), .o_wr_en(i_wr_en), .o_wr_idx(i_wr_idx), .o_wr_data(i_wr_data),
    .i_rd_valid(o_rd_valid), .i_rd_err(o_rd_err), .i_rd_data(o_rd_data),
    .i_wr_refused(o_wr_refused));

  // Clock at 100 ns period
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // Compare and access tasks
  // ---------------------------------------------------------------
  task automatic chk_word(input psir_word_t got, input psir_word_t exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read through the high-range instance and compare the answer
  task automatic rd_chk(input psir_idx_t idx, input psir_word_t exp, input logic err);
    logic v, e;
    psir_word_t d;
    psir_master_model_i.read(idx, v, e, d);
    chk_bit(v, 1'b1);
    chk_bit(e, err);
    chk_word(d, exp);
  endtask

  // Same read, judged on the low-range instance while its answer stands
  task automatic rd_lo(input psir_idx_t idx, input psir_word_t exp, input logic err);
    logic v, e;
    psir_word_t d;
    psir_master_model_i.read(idx, v, e, d);
    chk_bit(lo_valid, 1'b1);
    chk_bit(lo_err, err);
    chk_word(lo_data, exp);
  endtask

  // Snapshot lags inputs by one edge; two cycles leaves margin
  task automatic settle;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic test_done;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 180 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    $display("watchdog expired");
    test_done;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    fails = 0;
    compares = 0;
    i_resetn = 1'b0;
    {i_pressure, i_velocity, i_output_cmd, i_k_factor, i_dp_root, i_duct_area} = '0;
    {i_flow, i_span_f_low, i_alert_f_low} = '0;
    {i_span_p_low, i_span_v_low, i_alert_p_low, i_alert_v_low} = '0;
    {i_span_p_high, i_span_v_high, i_alert_p_high, i_alert_v_high} = '1;
    {i_span_f_high, i_alert_f_high} = '1;
    i_max_src = PSIR_SRC_KFACTOR;
    {i_velocity_en, i_pitot_present, i_autotune_busy} = 3'b000;
    {i_feedback_lost, i_sensor_failed} = 2'b00;
    repeat (20) @(negedge i_clk);
    chk_bit(o_rd_valid, 1'b0);
    chk_word(o_rd_data, 16'h0000);
    i_resetn = 1'b1;
    // Values, clamps and validity of flow and velocity
    i_pressure = 16'h0096;
    i_output_cmd = 16'h05dc;
    i_velocity = 16'h01f4;
    i_flow = 32'h0001_2345;
    settle;
    rd_chk(`PSIR_IDX_PRESSURE_LEVEL, 16'h0096, 1'b0);
    rd_chk(`PSIR_IDX_OUTPUT_PERCENT, `PSIR_OUT_RAW_MAX, 1'b0);
    rd_chk(`PSIR_IDX_AIR_VELOCITY, 16'h0000, 1'b0);
    rd_chk(`PSIR_IDX_FLOW_RATE_HIGH, 16'h0000, 1'b0);
    rd_chk(`PSIR_IDX_FLOW_RATE_LOW, 16'h0000, 1'b0);
    i_velocity_en = 1'b1;
    settle;
    rd_chk(`PSIR_IDX_AIR_VELOCITY, `PSIR_VEL_RAW_MAX, 1'b0);
    rd_chk(`PSIR_IDX_FLOW_RATE_LOW, 16'h0000, 1'b0);
    i_pitot_present = 1'b1;
    settle;
    rd_chk(`PSIR_IDX_FLOW_RATE_HIGH, 16'h0001, 1'b0);
    rd_chk(`PSIR_IDX_FLOW_RATE_LOW, 16'h2345, 1'b0);
    rd_lo(`PSIR_IDX_FLOW_RATE_HIGH, 16'h0000, 1'b1);
    rd_lo(`PSIR_IDX_FLOW_RATE_LOW, 16'h2345, 1'b0);
    i_output_cmd = 16'h03e7;
    i_velocity = 16'h012b;
    settle;
    rd_chk(`PSIR_IDX_OUTPUT_PERCENT, 16'h03e7, 1'b0);
    rd_chk(`PSIR_IDX_AIR_VELOCITY, 16'h012b, 1'b0);
    $display("test values done");
    // Maximum flow from K factor, then area, then an unknown source
    i_k_factor = 16'h1234;
    i_dp_root = 16'h0100;
    settle;
    rd_chk(`PSIR_IDX_MAX_FLOW_HIGH, 16'h0012, 1'b0);
    rd_chk(`PSIR_IDX_MAX_FLOW_LOW, 16'h3400, 1'b0);
    rd_lo(`PSIR_IDX_MAX_FLOW_HIGH, 16'h0000, 1'b1);
    rd_lo(`PSIR_IDX_MAX_FLOW_LOW, 16'h3400, 1'b0);
    i_max_src = PSIR_SRC_AREA;
    i_duct_area = 16'h03e8;
    exp_w = 16'((32'(i_duct_area) * 32'd300 * 32'd36) / 32'd1000);
    settle;
    rd_chk(`PSIR_IDX_MAX_FLOW_HIGH, 16'h0000, 1'b0);
    rd_chk(`PSIR_IDX_MAX_FLOW_LOW, exp_w, 1'b0);
    i_max_src = psir_src_e'(2'b00);
    settle;
    rd_chk(`PSIR_IDX_MAX_FLOW_LOW, 16'h0000, 1'b0);
    $display("test max flow done");
    // Span and alert windows on pressure, including the alert high boundary
    i_span_p_low = 16'h0064;
    i_span_p_high = 16'h00c8;
    i_alert_p_low = 16'h0078;
    i_alert_p_high = 16'h00b4;
    for (int n = 0; n < 5; n++) begin
      i_pressure = tab_p[n];
      settle;
      rd_chk(`PSIR_IDX_SPAN_FLAG, {15'h0000, tab_s[n]}, 1'b0);
      rd_chk(`PSIR_IDX_ALERT_FLAG, {15'h0000, tab_a[n]}, 1'b0);
    end
    i_autotune_busy = 1'b1;
    settle;
    rd_chk(`PSIR_IDX_SPAN_FLAG, 16'h0000, 1'b0);
    rd_chk(`PSIR_IDX_ALERT_FLAG, 16'h0000, 1'b0);
    i_autotune_busy = 1'b0;
    settle;
    rd_chk(`PSIR_IDX_SPAN_FLAG, 16'h0001, 1'b0);
    // Velocity counts toward span only while enabled
    i_pressure = 16'h0096;
    i_span_v_low = 16'h0064;
    i_velocity = 16'h000a;
    settle;
    rd_chk(`PSIR_IDX_SPAN_FLAG, 16'h0001, 1'b0);
    i_velocity_en = 1'b0;
    settle;
    rd_chk(`PSIR_IDX_SPAN_FLAG, 16'h0000, 1'b0);
    // Flow counts toward alert only with enable and probe
    i_velocity_en = 1'b1;
    i_span_v_low = 16'h0000;
    i_alert_f_high = 32'h0000_1000;
    settle;
    rd_chk(`PSIR_IDX_ALERT_FLAG, 16'h0001, 1'b0);
    i_pitot_present = 1'b0;
    settle;
    rd_chk(`PSIR_IDX_ALERT_FLAG, 16'h0000, 1'b0);
    $display("test flags done");
    // Feedback and sensor status, each set and clear
    for (int b = 0; b < 2; b++) begin
      i_feedback_lost = b[0];
      i_sensor_failed = ~b[0];
      settle;
      rd_chk(`PSIR_IDX_FEEDBACK_LOST, {15'h0000, b[0]}, 1'b0);
      rd_chk(`PSIR_IDX_SENSOR_FAULT, {15'h0000, ~b[0]}, 1'b0);
    end
    $display("test status done");
    // Reserved indices read zero, unmapped ones flag an error
    for (int x = 12; x <= 20; x++) begin
      rd_chk(psir_idx_t'(x), 16'h0000, 1'b0);
    end
    rd_chk(8'h00, 16'h0000, 1'b1);
    rd_chk(8'h15, 16'h0000, 1'b1);
    // The answer stands one cycle only; look after it has gone
    @(negedge i_clk);
    chk_bit(o_rd_valid, 1'b0);
    chk_word(o_rd_data, 16'h0000);
    $display("test map done");
    // Writes are refused and change nothing, one idle cycle apart
    psir_master_model_i.write(`PSIR_IDX_PRESSURE_LEVEL, 16'hffff, ref_bit);
    chk_bit(ref_bit, 1'b1);
    chk_bit(lo_refused, 1'b1);
    psir_master_model_i.write(`PSIR_IDX_SPAN_FLAG, 16'h0001, ref_bit);
    chk_bit(ref_bit, 1'b1);
    rd_chk(`PSIR_IDX_PRESSURE_LEVEL, 16'h0096, 1'b0);
    rd_chk(`PSIR_IDX_SPAN_FLAG, 16'h0000, 1'b0);
    $display("test writes done");
    // Mid-run reset: a strobe meanwhile gets no answer, values return after
    i_resetn = 1'b0;
    psir_master_model_i.write(`PSIR_IDX_PRESSURE_LEVEL, 16'h0000, ref_bit);
    chk_bit(ref_bit, 1'b0);
    i_resetn = 1'b1;
    settle;
    rd_chk(`PSIR_IDX_PRESSURE_LEVEL, 16'h0096, 1'b0);
    $display("test reset done");
    test_done;
  end
endmodule
